//--- hdl/two_wire_pkg.sv
// Constants shared by the two-wire serial port
package two_wire_pkg;
    // --------------------------------------------------------------
    // Register offsets
    // --------------------------------------------------------------
    localparam logic [7:0] STATUS_ADDR = 8'he8;
    localparam logic [7:0] DATA_ADDR = 8'he9;
    localparam logic [7:0] ADDRESS_ADDR = 8'he3;
    localparam logic [7:0] CONTROL_ADDR = 8'he5;
    localparam logic [7:0] IRQ_ADDR = 8'he6;
    // --------------------------------------------------------------
    // Control bits
    // --------------------------------------------------------------
    localparam int CTL_WORK = 0;
    localparam int CTL_SLEW = 1;
    localparam int CTL_CLKRUN = 2;
    localparam int CTL_WRSTR = 3;
    localparam int CTL_RDSTR = 4;
    localparam int CTL_MRST = 5;
    // Interrupt register: enable, flag, priority
    localparam int IRQ_EN = 0;
    localparam int IRQ_FLAG = 1;
    localparam int IRQ_PRI = 2;
    // Status bits
    localparam int ST_WCOL = 1;
    localparam int ST_RECOV = 0;
    localparam logic [7:0] STATUS_RESET = 8'h44;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] ACK_SLOT = 4'h9;
endpackage

//--- hdl/two_wire_link_if.sv
// Interface carrying bus events from the line watcher to the port core
`timescale 1ns/1ps
interface two_wire_link_if;
    logic sda_level;
    logic scl_rise;
    logic scl_fall;
    logic scl_level;
    logic start_ev;
    logic stop_ev;
    modport watcher (output sda_level, scl_rise, scl_fall, scl_level, start_ev, stop_ev);
    modport core (input sda_level, scl_rise, scl_fall, scl_level, start_ev, stop_ev);
endinterface

//--- hdl/two_wire_line_watch.sv
// Synchronises the bus lines and finds clock edges, start and stop
`timescale 1ns/1ps
module two_wire_line_watch
    import two_wire_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Bus lines
    input wire logic scl_i,
    input wire logic sda_i,
    // Events
    two_wire_link_if.watcher link
);
    typedef struct packed {
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic scl_old;
        logic sda_old;
    } watch_state_t;
    watch_state_t state_reg, state_next;

    always_comb begin
        state_next = state_reg;
        state_next.scl_sync = {state_reg.scl_sync[0], scl_i};
        state_next.sda_sync = {state_reg.sda_sync[0], sda_i};
        state_next.scl_old = state_reg.scl_sync[1];
        state_next.sda_old = state_reg.sda_sync[1];
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_reg <= '1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign link.scl_level = state_reg.scl_sync[1];
    assign link.sda_level = state_reg.sda_sync[1];
    assign link.scl_rise = state_reg.scl_sync[1] & ~state_reg.scl_old;
    assign link.scl_fall = ~state_reg.scl_sync[1] & state_reg.scl_old;
    // SDA moving while SCL high marks start (falling) or stop (rising)
    assign link.start_ev = state_reg.scl_sync[1] & state_reg.scl_old
                           & state_reg.sda_old & ~state_reg.sda_sync[1];
    assign link.stop_ev = state_reg.scl_sync[1] & state_reg.scl_old
                          & ~state_reg.sda_old & state_reg.sda_sync[1];
endmodule // two_wire_line_watch

//--- hdl/two_wire_port.sv
// Two-wire serial port target: registers, byte engine and clock holding
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module two_wire_port
    import two_wire_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [7:0] reg_rdata_o,
    // Bus pins, enable low while pulling the line low
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    // Pad and interrupt controller
    output logic slew_limit_on_o,
    output logic irq_o,
    output logic irq_high_pri_o
);
    typedef enum logic [2:0] {IDLE, ADDR, ADDR_ACK, RX, RX_ACK, TX, TX_ACK} phase_t;

    typedef struct packed {
        phase_t phase;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [7:0] buffer;
        logic [5:0] control;
        logic [6:0] own_addr;
        logic [2:0] irq;
        logic start_f;
        logic stop_f;
        logic dir_f;
        logic data_f;
        logic full_f;
        logic nack_f;
        logic wcol_f;
        logic recov_f;
        logic hold;
        logic drive_sda;
        logic [7:0] rdata;
    } port_state_t;
    port_state_t st_reg, st_next;

    two_wire_link_if link();

    two_wire_line_watch watch (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .link(link)
    );

    logic run;
    logic wr_buf;
    logic [7:0] status;

    // ------------------------------------------------------------------
    // Combined next state
    // ------------------------------------------------------------------
    assign run = st_reg.control[CTL_WORK] & ~st_reg.control[CTL_MRST];
    assign wr_buf = reg_write_i && reg_addr_i == DATA_ADDR;
    assign status = {st_reg.start_f, st_reg.stop_f, st_reg.dir_f, st_reg.data_f,
                     st_reg.full_f, st_reg.nack_f, st_reg.wcol_f, st_reg.recov_f};

    always_comb begin
        st_next = st_reg;
        st_next.rdata = ZERO_BYTE;
        // Register writes
        if (reg_write_i) begin
            case (reg_addr_i)
                CONTROL_ADDR: st_next.control = reg_wdata_i[5:0];
                ADDRESS_ADDR: st_next.own_addr = reg_wdata_i[7:1];
                IRQ_ADDR: st_next.irq = reg_wdata_i[2:0];
                STATUS_ADDR: begin
                    // Only zero clears; hardware sets below win the same cycle
                    if (!reg_wdata_i[ST_WCOL]) st_next.wcol_f = 1'b0;
                    if (!reg_wdata_i[ST_RECOV]) st_next.recov_f = 1'b0;
                end
                default: ;
            endcase
        end
        if (wr_buf) begin
            if (st_reg.phase == TX && st_reg.full_f) begin
                st_next.wcol_f = 1'b1;
            end else begin
                st_next.buffer = reg_wdata_i;
                st_next.full_f = st_reg.phase == TX || st_reg.phase == TX_ACK;
            end
        end
        // Register reads
        if (reg_read_i) begin
            case (reg_addr_i)
                STATUS_ADDR: st_next.rdata = status;
                DATA_ADDR: begin
                    st_next.rdata = st_reg.buffer;
                    if (st_reg.phase != TX) st_next.full_f = 1'b0;
                end
                CONTROL_ADDR: st_next.rdata = {2'b00, st_reg.control};
                ADDRESS_ADDR: st_next.rdata = {st_reg.own_addr, 1'b0};
                IRQ_ADDR: st_next.rdata = {5'h00, st_reg.irq};
                default: st_next.rdata = ZERO_BYTE;
            endcase
        end
        // Clock holding ends when software touches the buffer
        if (st_reg.hold && (wr_buf || (reg_read_i && reg_addr_i == DATA_ADDR)))
            st_next.hold = 1'b0;

        // --------------------------------------------------------------
        // Byte engine
        // --------------------------------------------------------------
        if (!run) begin
            st_next.phase = IDLE;
            st_next.drive_sda = 1'b0;
            st_next.hold = 1'b0;
        end else if (link.start_ev) begin
            st_next.start_f = 1'b1;
            st_next.stop_f = 1'b0;
            st_next.phase = ADDR;
            st_next.bit_cnt = '0;
            st_next.drive_sda = 1'b0;
        end else if (link.stop_ev) begin
            st_next.stop_f = 1'b1;
            st_next.start_f = 1'b0;
            st_next.phase = IDLE;
            st_next.drive_sda = 1'b0;
            st_next.hold = 1'b0;
        end else if (link.scl_rise) begin
            case (st_reg.phase)
                ADDR, RX: begin
                    st_next.shift = {st_reg.shift[6:0], link.sda_level};
                    st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
                end
                TX: st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
                TX_ACK: st_next.nack_f = link.sda_level;
                default: ;
            endcase
        end else if (link.scl_fall) begin
            case (st_reg.phase)
                ADDR: begin
                    if (st_reg.bit_cnt == BITS_PER_BYTE) begin
                        if (st_reg.shift[7:1] == st_reg.own_addr) begin
                            st_next.dir_f = st_reg.shift[0];
                            st_next.data_f = 1'b0;
                            st_next.drive_sda = 1'b1;
                            st_next.phase = ADDR_ACK;
                        end else begin
                            st_next.phase = IDLE;
                        end
                    end
                end
                ADDR_ACK, RX_ACK, TX_ACK: begin
                    st_next.bit_cnt = '0;
                    st_next.drive_sda = 1'b0;
                    if (st_reg.phase == TX_ACK && link.sda_level) begin
                        st_next.phase = IDLE;
                    end else if (st_reg.dir_f) begin
                        st_next.phase = TX;
                        st_next.shift = st_reg.buffer;
                        st_next.full_f = 1'b1;
                        st_next.drive_sda = ~st_reg.buffer[7];
                        st_next.data_f = 1'b1;
                    end else begin
                        st_next.phase = RX;
                    end
                end
                RX: begin
                    if (st_reg.bit_cnt == BITS_PER_BYTE) begin
                        st_next.data_f = 1'b1;
                        st_next.phase = RX_ACK;
                        if (st_reg.full_f) begin
                            st_next.recov_f = 1'b1;
                        end else begin
                            st_next.buffer = st_reg.shift;
                            st_next.full_f = 1'b1;
                            st_next.drive_sda = 1'b1;
                        end
                        st_next.irq[IRQ_FLAG] = 1'b1;
                        st_next.hold = st_reg.control[CTL_WRSTR];
                    end
                end
                TX: begin
                    if (st_reg.bit_cnt == BITS_PER_BYTE) begin
                        st_next.full_f = 1'b0;
                        st_next.drive_sda = 1'b0;
                        st_next.phase = TX_ACK;
                        st_next.irq[IRQ_FLAG] = 1'b1;
                        st_next.hold = st_reg.control[CTL_RDSTR];
                    end else begin
                        st_next.shift = {st_reg.shift[6:0], 1'b0};
                        st_next.drive_sda = ~st_reg.shift[6];
                    end
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_reg <= '0;
            st_reg.phase <= IDLE;
            st_reg.stop_f <= STATUS_RESET[6];
            st_reg.nack_f <= STATUS_RESET[2];
        end else if (st_reg.control[CTL_MRST] && !(reg_write_i && reg_addr_i == CONTROL_ADDR)) begin
            // Module reset keeps the control, address and interrupt registers but clears the data buffer and port logic
            st_reg <= '0;
            // Settings and read data stay live so software can leave reset
            st_reg.control <= st_next.control;
            st_reg.own_addr <= st_next.own_addr;
            st_reg.irq <= st_next.irq;
            st_reg.rdata <= st_next.rdata;
            st_reg.phase <= IDLE;
            st_reg.stop_f <= STATUS_RESET[6];
            st_reg.nack_f <= STATUS_RESET[2];
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata_o = st_reg.rdata;
    assign scl_o = 1'b0;
    assign scl_oe_n_o = ~(run & (~st_reg.control[CTL_CLKRUN] | st_reg.hold));
    assign sda_o = 1'b0;
    assign sda_oe_n_o = ~(run & st_reg.drive_sda);
    assign slew_limit_on_o = ~st_reg.control[CTL_SLEW];
    assign irq_o = st_reg.irq[IRQ_FLAG] & st_reg.irq[IRQ_EN];
    assign irq_high_pri_o = st_reg.irq[IRQ_PRI];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_idle_when_off;
        @(posedge sys_clk_i) disable iff (reset_i) !run |=> sda_oe_n_o;
    endproperty
    a_idle_when_off: assert property (p_idle_when_off) else $error("sda driven while off");

    property p_clock_low;
        @(posedge sys_clk_i) disable iff (reset_i)
            run && !st_reg.control[CTL_CLKRUN] |-> !scl_oe_n_o;
    endproperty
    a_clock_low: assert property (p_clock_low) else $error("clock not held low");

    property p_slew;
        @(posedge sys_clk_i) disable iff (reset_i)
            slew_limit_on_o == !st_reg.control[CTL_SLEW];
    endproperty
    a_slew: assert property (p_slew) else $error("slew select wrong");

    property p_start;
        @(posedge sys_clk_i) disable iff (reset_i)
            run && link.start_ev && !st_reg.control[CTL_MRST] |=> st_reg.start_f && !st_reg.stop_f;
    endproperty
    a_start: assert property (p_start) else $error("start flag missed");

    property p_stop;
        @(posedge sys_clk_i) disable iff (reset_i)
            run && link.stop_ev && !link.start_ev |=> st_reg.stop_f;
    endproperty
    a_stop: assert property (p_stop) else $error("stop flag missed");

    property p_wcol;
        @(posedge sys_clk_i) disable iff (reset_i)
            wr_buf && st_reg.phase == TX && st_reg.full_f && !st_reg.control[CTL_MRST]
            |=> st_reg.wcol_f && $stable(st_reg.buffer);
    endproperty
    a_wcol: assert property (p_wcol) else $error("collision not flagged");

    property p_read_clears;
        @(posedge sys_clk_i) disable iff (reset_i)
            reg_read_i && reg_addr_i == DATA_ADDR && st_reg.phase == IDLE && !wr_buf
            && !st_reg.control[CTL_MRST] |=> !st_reg.full_f;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("full not cleared");

    property p_irq;
        @(posedge sys_clk_i) disable iff (reset_i)
            irq_o |-> st_reg.irq[IRQ_EN] ##0 $past(st_reg.irq[IRQ_FLAG]) || st_reg.irq[IRQ_FLAG];
    endproperty
    a_irq: assert property (p_irq) else $error("irq not gated");
endmodule // two_wire_port

//--- tb/two_wire_far_master.sv
// Behavioural bus master standing on the far side of the two-wire port
`timescale 1ns/1ps
module two_wire_far_master (
    // Wired-and line levels
    input wire logic scl_i,
    input wire logic sda_i,
    // Pull-down requests and hang report
    output logic scl_pull_o,
    output logic sda_pull_o,
    output logic hang_o
);
    // ------------------------------------------------------------
    // Bit slots, 200 ns nominal, stretched while the port holds the clock
    // ------------------------------------------------------------
    initial begin
        scl_pull_o = 1'b0;
        sda_pull_o = 1'b0;
        hang_o = 1'b0;
    end

    task automatic bit_slot(input logic pull, output logic seen);
        int n;
        sda_pull_o = pull;
        #50;
        scl_pull_o = 1'b0;
        n = 0;
        // A held clock is waited out, but never forever
        while (scl_i !== 1'b1 && n < 4000) begin
            #25;
            n++;
        end
        if (n >= 4000) hang_o = 1'b1;
        #50;
        seen = sda_i;
        #50;
        scl_pull_o = 1'b1;
        #50;
    endtask

    task automatic start_cond();
        sda_pull_o = 1'b1;
        #100;
        scl_pull_o = 1'b1;
        #50;
    endtask

    task automatic stop_cond();
        sda_pull_o = 1'b1;
        #50;
        scl_pull_o = 1'b0;
        #100;
        sda_pull_o = 1'b0;
        #100;
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic d;
        for (int i = 7; i >= 0; i--) bit_slot(~b[i], d);
        bit_slot(1'b0, ack);
    endtask

    task automatic get_byte(input logic nack, output logic [7:0] b);
        logic d;
        for (int i = 7; i >= 0; i--) bit_slot(1'b0, b[i]);
        bit_slot(~nack, d);
    endtask
endmodule // two_wire_far_master

//--- tb/tb.sv
// Self-checking bench for the two-wire port
`timescale 1ns/1ps
module tb;
    import two_wire_pkg::*;
    typedef struct packed {
        logic [7:0] exp;
        logic [7:0] mask;
    } note_t;
    logic sys_clk_i, reset_i, reg_write_i, reg_read_i, rd_seen;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, own, d1, d2, d3, rx;
    logic scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, slew_limit_on_o, irq_o, irq_high_pri_o;
    logic scl_pull, sda_pull, bus_hang, scl_w, sda_w, ack;
    int errors, comparisons;
    note_t notes[$];
    note_t n;

    // Pull-ups on both lines: any party pulling wins
    assign scl_w = scl_pull ? 1'b0 : (scl_oe_n_o ? 1'b1 : scl_o);
    assign sda_w = sda_pull ? 1'b0 : (sda_oe_n_o ? 1'b1 : sda_o);
    always #12.5 sys_clk_i = ~sys_clk_i;

    two_wire_port u_two_wire_port (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
        .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .scl_i(scl_w), .scl_o(scl_o),
        .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
        .slew_limit_on_o(slew_limit_on_o), .irq_o(irq_o), .irq_high_pri_o(irq_high_pri_o));
    two_wire_far_master u_two_wire_far_master (.scl_i(scl_w), .sda_i(sda_w),
        .scl_pull_o(scl_pull), .sda_pull_o(sda_pull), .hang_o(bus_hang));

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge sys_clk_i) begin
        if (rd_seen === 1'b1) begin
            n = notes.pop_front();
            check(reg_rdata_o & n.mask, n.exp);
        end
        rd_seen <= reg_read_i;
    end

    always @(posedge sys_clk_i) begin
        if (bus_hang === 1'b1) begin
            errors++;
            finish_test();
        end
    end

    initial begin
        repeat (30000) @(posedge sys_clk_i);
        errors++;
        finish_test();
    end

    // ------------------------------------------------------------
    // Register port cycles
    // ------------------------------------------------------------
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_write_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        notes.push_back('{e, m});
        @(posedge sys_clk_i);
        reg_read_i <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        sys_clk_i = 1'b0;
        reset_i = 1'b1;
        reg_write_i = 1'b0;
        reg_read_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        rd_seen = 1'b0;
        errors = 0;
        comparisons = 0;
        void'($urandom(32'h57e2e49d));
        own = 8'($urandom) & 8'hfe;
        d1 = 8'($urandom);
        d2 = ~d1;
        d3 = 8'($urandom);
        repeat (3) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        rd(STATUS_ADDR, STATUS_RESET, 8'hff);
        rd(DATA_ADDR, ZERO_BYTE, 8'hff);
        rd(8'he0, ZERO_BYTE, 8'hff);
        check({7'h00, slew_limit_on_o}, 8'h01);
        // Port off: own address must not be answered
        wr(CONTROL_ADDR, 8'h04);
        wr(ADDRESS_ADDR, own);
        rd(ADDRESS_ADDR, own, 8'hfe);
        u_two_wire_far_master.start_cond();
        u_two_wire_far_master.send_byte({own[7:1], 1'b0}, ack);
        check({7'h00, ack}, 8'h01);
        u_two_wire_far_master.stop_cond();
        wr(CONTROL_ADDR, 8'h01);
        cyc(3);
        check({7'h00, scl_oe_n_o}, 8'h00);
        check({7'h00, slew_limit_on_o}, 8'h01);
        wr(CONTROL_ADDR, 8'h07);
        wr(IRQ_ADDR, 8'h05);
        cyc(3);
        check({6'h00, scl_oe_n_o, slew_limit_on_o}, 8'h02);
        check({7'h00, irq_high_pri_o}, 8'h01);
        // Master writes two bytes, the second over an unread first
        u_two_wire_far_master.start_cond();
        cyc(8);
        rd(STATUS_ADDR, 8'h80, 8'hc0);
        u_two_wire_far_master.send_byte({own[7:1], 1'b0}, ack);
        check({7'h00, ack}, 8'h00);
        rd(STATUS_ADDR, 8'h00, 8'h30);
        u_two_wire_far_master.send_byte(d1, ack);
        cyc(8);
        rd(STATUS_ADDR, 8'h18, 8'h18);
        check({7'h00, irq_o}, 8'h01);
        u_two_wire_far_master.send_byte(d2, ack);
        check({7'h00, ack}, 8'h01);
        rd(STATUS_ADDR, 8'h01, 8'h01);
        wr(STATUS_ADDR, 8'h00);
        rd(STATUS_ADDR, 8'h00, 8'h03);
        rd(DATA_ADDR, d1, 8'hff);
        rd(STATUS_ADDR, 8'h00, 8'h08);
        wr(IRQ_ADDR, 8'h06);
        cyc(3);
        check({7'h00, irq_o}, 8'h00);
        rd(IRQ_ADDR, 8'h02, 8'h02);
        wr(IRQ_ADDR, 8'h01);
        u_two_wire_far_master.stop_cond();
        cyc(8);
        rd(STATUS_ADDR, 8'h40, 8'h40);
        // Clock holding after a received byte until software reads it
        u_two_wire_far_master.start_cond();
        u_two_wire_far_master.send_byte({own[7:1], 1'b0}, ack);
        wr(CONTROL_ADDR, 8'h0f);
        // The master waits on the held clock, so software runs beside it
        fork
            u_two_wire_far_master.send_byte(d3, ack);
            begin
                cyc(80);
                check({7'h00, scl_oe_n_o}, 8'h00);
                rd(DATA_ADDR, d3, 8'hff);
            end
        join
        check({7'h00, ack}, 8'h00);
        cyc(8);
        check({7'h00, scl_oe_n_o}, 8'h01);
        u_two_wire_far_master.stop_cond();
        wr(CONTROL_ADDR, 8'h07);
        // Master reads; software collides with the byte in flight
        wr(DATA_ADDR, d2);
        u_two_wire_far_master.start_cond();
        u_two_wire_far_master.send_byte({own[7:1], 1'b1}, ack);
        rd(STATUS_ADDR, 8'h20, 8'h20);
        fork
            u_two_wire_far_master.get_byte(1'b1, rx);
            begin
                cyc(24);
                rd(STATUS_ADDR, 8'h08, 8'h08);
                wr(DATA_ADDR, d1);
            end
        join
        check(rx, d2);
        cyc(8);
        check({7'h00, scl_oe_n_o}, 8'h01);
        rd(STATUS_ADDR, 8'h06, 8'h0e);
        u_two_wire_far_master.stop_cond();
        // Module reset brings the flags back while settings stay
        wr(CONTROL_ADDR, 8'h27);
        rd(STATUS_ADDR, STATUS_RESET, 8'hff);
        rd(CONTROL_ADDR, 8'h27, 8'hff);
        wr(CONTROL_ADDR, 8'h07);
        cyc(4);
        finish_test();
    end
endmodule // tb
